//--- logic/mmcf_if.sv
// signals between the counter core, the shift sequencer and the storage register
`timescale 1ns/1ns
interface mmcf_if;
  import mmcf_pkg::*;
  logic [CNT_W-1:0] cnt;
  logic [CTRL_MODE_W-1:0] mode;
  logic [CNT_W-1:0] shift_next;
  logic capture;
  logic clear;
  logic [CNT_W-1:0] stored;
  modport core (output cnt, output mode, output capture, output clear,
                input shift_next, input stored);
  modport seq (input cnt, input mode, output shift_next);
  modport store (input cnt, input capture, input clear, output stored);
endinterface

//--- logic/mmcf_pkg.sv
// shared constants, register map and mode encoding of the multimode counter
package mmcf_pkg;
  // ==========================================================
  // widths
  localparam int CNT_W = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STORE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h10;
  // ==========================================================
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 4;
  localparam int CTRL_DIR_BIT = 4;
  localparam int CTRL_EN_BIT = 5;
  localparam int CMD_LOAD_BIT = 0;
  localparam int CMD_STORE_BIT = 1;
  localparam int CMD_CLEAR_BIT = 2;
  // ==========================================================
  // values after reset
  localparam logic [CTRL_MODE_W-1:0] MODE_RESET = 4'h0;
  localparam logic DIR_RESET = 1'b1;
  localparam logic EN_RESET = 1'b1;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [CNT_W-1:0] PRESET_RESET = 6'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  // ==========================================================
  // terminal counts and ring lengths
  localparam logic [3:0] DEC_LAST = 4'h9;
  localparam logic [2:0] QUIN_LAST = 3'h4;
  localparam logic [3:0] BIN16_LAST = 4'hF;
  localparam logic [4:0] BIN32_LAST = 5'h1F;
  localparam int RING5_LEN = 5;
  localparam int RING6_LEN = 6;
  localparam int TWIST3_LEN = 3;
  localparam int TWIST4_LEN = 4;
  localparam int TWIST5_LEN = 5;
  // ==========================================================
  // counting modes
  typedef enum logic [CTRL_MODE_W-1:0] {
    MODE_DEC8421,
    MODE_BIQUIN,
    MODE_DEC1242,
    MODE_BIN16,
    MODE_BIN32,
    MODE_UPDOWN,
    MODE_RING5,
    MODE_RING6,
    MODE_TWIST3,
    MODE_TWIST4,
    MODE_TWIST5
  } mmcf_mode_type;
endpackage

//--- logic/mmcf_seq.sv
// next state of the ring and twisted-ring counting modes
`timescale 1ns/1ns
module mmcf_seq
  import mmcf_pkg::*;
(
  mmcf_if.seq bus
);
  // ==========================================================
  // shift step
  function automatic logic [CNT_W-1:0] shift_step(input logic [CNT_W-1:0] q,
                                                  input int len,
                                                  input logic twist);
    logic [CNT_W-1:0] r;
    logic all_zero;
    r = '0;
    all_zero = 1'b1;
    for (int i = 1; i < CNT_W; i++) begin
      if (i < len) begin
        r[i] = q[i-1];
      end
    end
    for (int i = 0; i < CNT_W - 1; i++) begin
      if (i < len - 1) begin
        all_zero = all_zero & ~q[i];
      end
    end
    if (twist) begin
      // last, next-to-last and first stages steer the first; escapes 010/101 style loops
      r[0] = ~q[len-1] & (q[0] | ~q[len-2]);
    end else begin
      // zeros enter until the feedback stages are clear, then a single one
      r[0] = all_zero;
    end
    return r;
  endfunction

  always_comb begin
    case (mmcf_mode_type'(bus.mode))
      MODE_RING5: bus.shift_next = shift_step(bus.cnt, RING5_LEN, 1'b0);
      MODE_RING6: bus.shift_next = shift_step(bus.cnt, RING6_LEN, 1'b0);
      MODE_TWIST3: bus.shift_next = shift_step(bus.cnt, TWIST3_LEN, 1'b1);
      MODE_TWIST4: bus.shift_next = shift_step(bus.cnt, TWIST4_LEN, 1'b1);
      MODE_TWIST5: bus.shift_next = shift_step(bus.cnt, TWIST5_LEN, 1'b1);
      default: bus.shift_next = bus.cnt;
    endcase
  end
endmodule

//--- logic/mmcf_store.sv
// count-and-store holding register
`timescale 1ns/1ns
module mmcf_store
  import mmcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  mmcf_if.store bus
);
  typedef struct packed {
    logic [CNT_W-1:0] stored;
  } mmcf_store_state_type;

  mmcf_store_state_type state;
  mmcf_store_state_type next_state;

  always_comb begin
    next_state = state;
    if (bus.clear) begin
      next_state.stored = CNT_RESET;
    end else if (bus.capture) begin
      // parallel copy; the counter itself is never held for it
      next_state.stored = bus.cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bus.stored = state.stored;
endmodule

//--- logic/mmcf_top.sv
// multimode counter with strobed preset, count-and-store and an apb register port
`timescale 1ns/1ns
module mmcf_top
  import mmcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_in,
  input wire logic strobe_in,
  input wire logic store_in,
  output logic [CNT_W-1:0] count_out,
  output logic [CNT_W-1:0] stored_out,
  output logic carry_out
);
  // ==========================================================
  // state
  typedef struct packed {
    logic count_meta;
    logic count_sync;
    logic count_prev;
    logic strobe_meta;
    logic strobe_sync;
    logic store_meta;
    logic store_sync;
    logic store_prev;
    logic [CTRL_MODE_W-1:0] mode;
    logic dir;
    logic enable;
    logic [CNT_W-1:0] preset;
    logic [CNT_W-1:0] cnt;
    logic carry;
    logic capture;
    logic clear;
    logic [CNT_W-1:0] stored;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } mmcf_core_state_type;

  typedef struct packed {
    logic wrap;
    logic [CNT_W-1:0] value;
  } mmcf_step_type;

  mmcf_core_state_type state;
  mmcf_core_state_type next_state;
  mmcf_if link ();

  // ==========================================================
  // submodules
  mmcf_seq u_seq (
    .bus (link.seq)
  );

  mmcf_store u_store (
    .pclk (pclk),
    .presetn (presetn),
    .bus (link.store)
  );

  assign link.cnt = state.cnt;
  assign link.mode = state.mode;
  assign link.capture = state.capture;
  assign link.clear = state.clear;

  // ==========================================================
  // decode helpers
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == OFS_CTRL) begin
      hit = 1'b1;
    end else if (addr == OFS_PRESET) begin
      hit = 1'b1;
    end else if (addr == OFS_COUNT) begin
      hit = 1'b1;
    end else if (addr == OFS_STORE) begin
      hit = 1'b1;
    end else if (addr == OFS_CMD) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // stages that take part in the selected mode; loads are cut to this width
  function automatic logic [CNT_W-1:0] mode_mask(input logic [CTRL_MODE_W-1:0] m);
    logic [CNT_W-1:0] r;
    r = 6'h0F;
    case (mmcf_mode_type'(m))
      MODE_BIN32: r = 6'h1F;
      MODE_UPDOWN: r = 6'h1F;
      MODE_RING5: r = 6'h1F;
      MODE_RING6: r = 6'h3F;
      MODE_TWIST3: r = 6'h07;
      MODE_TWIST4: r = 6'h0F;
      MODE_TWIST5: r = 6'h1F;
      default: r = 6'h0F;
    endcase
    return r;
  endfunction

  // 1-2-4-2 code: bit3 weight 2, bit2 weight 4, bit1 weight 2, bit0 weight 1
  function automatic logic [3:0] step_1242(input logic [3:0] q);
    logic [3:0] r;
    r = 4'h0;
    case (q)
      4'h0: r = 4'h1;
      4'h1: r = 4'h2;
      4'h2: r = 4'h3;
      4'h3: r = 4'h4;
      4'h4: r = 4'h5;
      4'h5: r = 4'h6;
      4'h6: r = 4'h7;
      4'h7: r = 4'hE;
      4'hE: r = 4'hF;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // one count step of the arithmetic modes; the shift modes come from the sequencer
  function automatic mmcf_step_type count_step(input logic [CTRL_MODE_W-1:0] m,
                                               input logic [CNT_W-1:0] q,
                                               input logic up,
                                               input logic [CNT_W-1:0] shifted);
    mmcf_step_type r;
    r.wrap = 1'b0;
    r.value = q;
    case (mmcf_mode_type'(m))
      MODE_DEC8421: begin
        r.wrap = (q[3:0] >= DEC_LAST);
        r.value = r.wrap ? CNT_RESET : {2'b00, q[3:0] + 4'h1};
      end
      MODE_BIQUIN: begin
        // bits 3:1 hold the divide-by-five, bit 0 toggles on its wrap
        if (q[3:1] >= QUIN_LAST) begin
          r.wrap = q[0];
          r.value = {2'b00, 3'h0, ~q[0]};
        end else begin
          r.value = {2'b00, q[3:1] + 3'h1, q[0]};
        end
      end
      MODE_DEC1242: begin
        r.value = {2'b00, step_1242(q[3:0])};
        r.wrap = (r.value == CNT_RESET);
      end
      MODE_BIN16: begin
        r.wrap = (q[3:0] == BIN16_LAST);
        r.value = {2'b00, q[3:0] + 4'h1};
      end
      MODE_BIN32: begin
        r.wrap = (q[4:0] == BIN32_LAST);
        r.value = {1'b0, q[4:0] + 5'h01};
      end
      MODE_UPDOWN: begin
        // next value always derives from the settled count, so a turn-around
        // between two steps cannot leave a half-updated value
        if (up) begin
          r.wrap = (q[4:0] == BIN32_LAST);
          r.value = {1'b0, q[4:0] + 5'h01};
        end else begin
          r.wrap = (q[4:0] == 5'h00);
          r.value = {1'b0, q[4:0] - 5'h01};
        end
      end
      MODE_RING5, MODE_RING6: begin
        r.value = shifted;
        r.wrap = (shifted == 6'h01);
      end
      MODE_TWIST3, MODE_TWIST4, MODE_TWIST5: begin
        r.value = shifted;
        r.wrap = (shifted == CNT_RESET);
      end
      default: begin
        r.wrap = 1'b0;
        r.value = q;
      end
    endcase
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic tick;
    logic store_edge;
    logic wr_go;
    logic rd_setup;
    logic cmd_load;
    logic cmd_store;
    logic cmd_clear;
    mmcf_step_type step;
    tick = 1'b0;
    store_edge = 1'b0;
    wr_go = 1'b0;
    rd_setup = 1'b0;
    cmd_load = 1'b0;
    cmd_store = 1'b0;
    cmd_clear = 1'b0;
    step = '0;
    next_state = state;
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    next_state.carry = 1'b0;
    next_state.capture = 1'b0;
    next_state.clear = 1'b0;

    // pin synchronisers: the first stage is never looked at
    next_state.count_meta = count_in;
    next_state.count_sync = state.count_meta;
    next_state.count_prev = state.count_sync;
    next_state.strobe_meta = strobe_in;
    next_state.strobe_sync = state.strobe_meta;
    next_state.store_meta = store_in;
    next_state.store_sync = state.store_meta;
    next_state.store_prev = state.store_sync;

    // count enable exists only at the rising edge of the count input;
    // a low count input keeps every stage disabled, whatever the direction
    tick = state.count_sync & ~state.count_prev & state.enable;
    store_edge = state.store_sync & ~state.store_prev;

    // ========================================================
    // apb slave: zero wait states, answer in the first access cycle
    rd_setup = psel & ~penable;
    wr_go = psel & penable & state.pready & pwrite;
    if (rd_setup) begin
      next_state.pready = 1'b1;
      next_state.pslverr = ~reg_hit(paddr);
      next_state.prdata = RDATA_RESET;
      if (!pwrite) begin
        if (paddr == OFS_CTRL) begin
          next_state.prdata[CTRL_MODE_LSB +: CTRL_MODE_W] = state.mode;
          next_state.prdata[CTRL_DIR_BIT] = state.dir;
          next_state.prdata[CTRL_EN_BIT] = state.enable;
        end else if (paddr == OFS_PRESET) begin
          next_state.prdata[CNT_W-1:0] = state.preset;
        end else if (paddr == OFS_COUNT) begin
          next_state.prdata[CNT_W-1:0] = state.cnt;
        end else if (paddr == OFS_STORE) begin
          next_state.prdata[CNT_W-1:0] = link.stored;
        end
      end
    end
    if (wr_go) begin
      if (paddr == OFS_CTRL) begin
        // takes hold at this edge, so the next count step uses it
        next_state.mode = pwdata[CTRL_MODE_LSB +: CTRL_MODE_W];
        next_state.dir = pwdata[CTRL_DIR_BIT];
        next_state.enable = pwdata[CTRL_EN_BIT];
      end else if (paddr == OFS_PRESET) begin
        next_state.preset = pwdata[CNT_W-1:0];
      end else if (paddr == OFS_CMD) begin
        cmd_load = pwdata[CMD_LOAD_BIT];
        cmd_store = pwdata[CMD_STORE_BIT];
        cmd_clear = pwdata[CMD_CLEAR_BIT];
      end
    end

    // ========================================================
    // counter stages: clear, then strobed preset, then counting
    step = count_step(state.mode, state.cnt, state.dir, link.shift_next);
    if (cmd_clear) begin
      next_state.cnt = CNT_RESET;
      next_state.clear = 1'b1;
    end else if (state.strobe_sync || cmd_load) begin
      // any state may be entered; unused codes are left by the mode's own logic
      next_state.cnt = state.preset & mode_mask(state.mode);
    end else if (tick) begin
      // a preset start runs out to the wrap, then the full modulus follows
      next_state.cnt = step.value & mode_mask(state.mode);
      next_state.carry = step.wrap;
    end

    // ========================================================
    // count and store: copy the running count without stalling it
    if (!cmd_clear && (store_edge || cmd_store)) begin
      next_state.capture = 1'b1;
    end
    next_state.stored = link.stored;
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
      state.mode <= MODE_RESET;
      state.dir <= DIR_RESET;
      state.enable <= EN_RESET;
      state.preset <= PRESET_RESET;
      state.cnt <= CNT_RESET;
      state.prdata <= RDATA_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs, each from a flip-flop
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign count_out = state.cnt;
  // stored is a copy of the storage register, one cycle behind it
  assign stored_out = state.stored;
  assign carry_out = state.carry;
endmodule

//--- test/mmcf_chk.sv
// assertion checker on the multimode counter top ports
`timescale 1ns/1ns
module mmcf_chk
  import mmcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic count_in,
  input wire logic strobe_in,
  input wire logic store_in,
  input wire logic [CNT_W-1:0] count_out,
  input wire logic [CNT_W-1:0] stored_out,
  input wire logic carry_out
);
  // ==========
  // quiet counters: saturate so long idle spans never wrap back to zero
  logic [3:0] cq;
  logic [3:0] sq;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cq <= 4'h0;
      sq <= 4'h0;
    end else begin
      cq <= (count_in || strobe_in || psel) ? 4'h0 : cq + {3'h0, cq != 4'hF};
      sq <= (store_in || psel) ? 4'h0 : sq + {3'h0, sq != 4'hF};
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_done;
  endproperty
  a_answer: assert property (p_answer) else $error("setup not answered next cycle");
  property p_idle_ready;
    !psel |-> !pready;
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("ready without select");
  property p_unmapped;
    psel && !penable && paddr > 8'h13 |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");
  property p_err_zero;
    pready && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
  property p_upper_zero;
    s_done ##0 !pwrite |-> prdata[DATA_W-1:CNT_W] == 26'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
  property p_hold;
    cq >= 4'h4 |-> $stable(count_out);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without a cause");
  property p_store_quiet;
    sq >= 4'h8 |-> $stable(stored_out);
  endproperty
  a_store_quiet: assert property (p_store_quiet) else $error("store moved uncalled");
  property p_carry_step;
    carry_out |-> !$stable(count_out);
  endproperty
  a_carry_step: assert property (p_carry_step) else $error("carry without a step");
  property p_carry_once;
    carry_out |=> !carry_out;
  endproperty
  a_carry_once: assert property (p_carry_once) else $error("carry longer than one cycle");
  property p_strobe;
    (strobe_in && !psel)[*5] |-> $stable(count_out);
  endproperty
  a_strobe: assert property (p_strobe) else $error("count moved under strobe");
endmodule
bind mmcf_top mmcf_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .count_in(count_in), .strobe_in(strobe_in), .store_in(store_in),
  .count_out(count_out), .stored_out(stored_out), .carry_out(carry_out));

//--- test/test_multimode_counter_family.sv
// self-checking bench for the multimode counter over apb and its pins
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_multimode_counter_family;
  import mmcf_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic count_in = 1'b0, strobe_in = 1'b0, store_in = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [DATA_W-1:0] prdata, rd;
  logic pready, pslverr, carry_out, err, saw_carry;
  logic [CNT_W-1:0] count_out, stored_out, q;
  int n_errors = 0;
  int tests_run = 0;
  // start points: short first cycles and unused ring states
  localparam logic [CNT_W-1:0] START [11] = '{6'h07, 6'h08, 6'h06, 6'h0E, 6'h1E, 6'h1F,
    6'h15, 6'h2A, 6'h05, 6'h0A, 6'h14};
  mmcf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_in(count_in), .strobe_in(strobe_in), .store_in(store_in),
    .count_out(count_out), .stored_out(stored_out), .carry_out(carry_out));
  initial begin
    forever #20 pclk = ~pclk;
  end
  // ==========
  // reference next count
  function automatic logic [CNT_W-1:0] nxt(input int m, input logic [CNT_W-1:0] v,
      input logic up);
    int l;
    l = (m < 8) ? m - 1 : m - 5;
    case (m)
      0: return (v == 6'h09) ? 6'h00 : v + 6'h01;
      1: return (v[3:1] == 3'h4) ? {5'h00, ~v[0]} : v + 6'h02;
      2: return (v == 6'h0F) ? 6'h00 : (v == 6'h07) ? 6'h0E : v + 6'h01;
      3: return {2'h0, v[3:0] + 4'h1};
      4: return {1'b0, v[4:0] + 5'h01};
      5: return up ? {1'b0, v[4:0] + 5'h01} : {1'b0, v[4:0] - 5'h01};
      6, 7: return ((v & ((6'h01 << (l - 1)) - 6'h01)) == 6'h00) ? 6'h01 :
        (v << 1) & ((6'h01 << l) - 6'h01);
      8, 9, 10: return ((v << 1) | {5'h00, ~v[l-1] & (v[0] | ~v[l-2])}) &
        ((6'h01 << l) - 6'h01);
      default: return v;
    endcase
  endfunction
  // ==========
  // apb master and pin drivers
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
    `CHK(err, ee)
  endtask
  task automatic load(input logic [CNT_W-1:0] v);
    wr(OFS_PRESET, {26'h0, v});
    wr(OFS_CMD, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    `CHK(count_out, v)
  endtask
  // one count pulse, high and low three cycles each; carry seen anywhere counts
  task automatic step;
    saw_carry = 1'b0;
    @(posedge pclk);
    count_in <= 1'b1;
    // pin stays high three cycles, well above the one-cycle minimum
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      saw_carry = saw_carry | carry_out;
      if (i == 2) count_in <= 1'b0;
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    wrap_up;
  end
  // ==========
  // scenarios
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_CTRL, 32'h0000_0030, 1'b0);
    for (int i = 1; i < 5; i++) rdchk(ADDR_W'(4 * i), 32'h0000_0000, 1'b0);
    rdchk(8'h20, 32'h0000_0000, 1'b1);
    wr(8'h40, 32'h0000_0001);
    `CHK(err, 1'b1)
    for (int m = 0; m < 11; m++) begin
      wr(OFS_CTRL, 32'h0000_0030 | 32'(m));
      load(START[m]);
      q = START[m];
      repeat (18) begin
        step;
        `CHK(saw_carry, nxt(m, q, 1'b1) == ((m == 6 || m == 7) ? 6'h01 : 6'h00))
        q = nxt(m, q, 1'b1);
        `CHK(count_out, q)
      end
    end
    wr(OFS_CTRL, 32'h0000_0025);
    load(6'h01);
    q = 6'h01;
    for (int i = 0; i < 5; i++) begin
      step;
      q = nxt(5, q, i > 2);
      `CHK(count_out, q)
      if (i == 2) wr(OFS_CTRL, 32'h0000_0035);
    end
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, i ? 32'h0000_003B : 32'h0000_0010);
      step;
      `CHK(count_out, q)
    end
    wr(OFS_CTRL, 32'h0000_0030);
    wr(OFS_PRESET, 32'h0000_0027);
    strobe_in <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK(count_out, 6'h07)
    step;
    `CHK(count_out, 6'h07)
    strobe_in <= 1'b0;
    repeat (4) @(posedge pclk);
    q = 6'h07;
    repeat (4) begin
      step;
      `CHK(saw_carry, q == 6'h09)
      q = nxt(0, q, 1'b1);
      `CHK(count_out, q)
    end
    store_in <= 1'b1;
    repeat (3) @(posedge pclk);
    store_in <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK(stored_out, q)
    step;
    `CHK(count_out, 6'h02)
    rdchk(OFS_STORE, {26'h0, q}, 1'b0);
    wr(OFS_COUNT, 32'h0000_0005);
    rdchk(OFS_COUNT, 32'h0000_0002, 1'b0);
    wr(OFS_CMD, 32'h0000_0002);
    repeat (4) @(posedge pclk);
    `CHK(stored_out, 6'h02)
    wr(OFS_CMD, 32'h0000_0004);
    repeat (3) @(posedge pclk);
    `CHK(count_out, 6'h00)
    `CHK(stored_out, 6'h00)
    wrap_up;
  end
endmodule
